// ### src/fbrg_pkg.sv
// constants of the fractional baud rate generator
package fbrg_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTL = 8'h00;
  localparam logic [7:0] ADDR_FD = 8'h04;
  localparam logic [7:0] ADDR_LEG = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  // baud_prescale_control fields
  localparam int CTL_EN_BIT = 7;
  localparam logic [7:0] CTL_RSVD_MASK = 8'h78;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] FD_RESET = 8'h00;
  // legacy serial configuration fields
  localparam int LEG_DBL_BIT = 7;
  localparam int LEG_RCLK_BIT = 5;
  localparam int LEG_TX_TIMER_SELECT_BIT = 4;
  localparam logic [7:0] LEG_RESET = 8'h00;
  // status fields
  localparam int STAT_ACT_BIT = 0;
  localparam int STAT_ACC_LSB = 8;
  // generator arithmetic
  localparam logic [8:0] FD_OFFSET = 9'h040;
  localparam logic [8:0] GEN_STEP = 9'h002;
  // legacy and fixed division counts
  localparam logic [6:0] T1_DIV = 7'h20;
  localparam logic [6:0] T1_DIV_DBL = 7'h10;
  localparam logic [6:0] T2_DIV = 7'h10;
  localparam logic [6:0] MODE0_DIV = 7'h0C;
  localparam logic [6:0] MODE2_DIV = 7'h40;
  localparam logic [6:0] MODE2_DIV_DBL = 7'h20;
endpackage : fbrg_pkg

// ### src/fbrg_top.sv
// fractional baud rate generator with ahb-lite register slave
//
// Notes on behaviour
// R01 - enable bit selects dedicated generator for rate
// R02 - enabled: ignore doubling and timer select bits
// R03 - disabled: legacy timer or fixed division used
// R04 - prescale field divides clock by two power
// R05 - control bits six to three reserved
// R06 - rate is 2f over prescale times (fd+64)
// R07 - generator runs from core clock directly
// R08 - software picks prescale from log2 formula
// R09 - software picks fractional value, rounded nearest
// R10 - range 12 to 393216 bit/s reachable
// R11 - 80h with 2dh gives 230400 at max
// R12 - legacy modes use timer one/two overflows
// R13 - doubling bit halves timer-one legacy and mode-2 division
// R14 - generator serves tx and rx, modes 1/3
//
// Design decisions made here: register access over AHB-Lite and the register addresses.
`timescale 1ns/10ps
module fbrg_top
  import fbrg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic t1_ovf,
  input wire logic t2_ovf,
  output logic tx_bit_en,
  output logic rx_bit_en,
  output logic gen_active
);

  typedef struct packed {
    logic [7:0] ctl_r;
    logic [7:0] fd_r;
    logic [7:0] leg_r;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic [6:0] pre_r;
    logic [8:0] acc_r;
    logic [6:0] txd_r;
    logic [6:0] rxd_r;
    logic [6:0] fix_r;
    logic tx_en_r;
    logic rx_en_r;
    logic gen_act_r;
  } fbrg_state_s;

  fbrg_state_s st_r;
  fbrg_state_s st_nxt;

  logic addr_ok;
  logic en;
  logic var_mode;
  logic gen;
  logic pre_hit;
  logic gen_tick;
  logic [6:0] pre_mask_v;
  logic [8:0] modulus;
  logic [8:0] sum;
  logic [6:0] tx_lim;
  logic [6:0] rx_lim;
  logic [6:0] fix_lim;
  logic tx_ovf;
  logic rx_ovf;
  logic leg_tx;
  logic leg_rx;
  logic fix_tick;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] pre_mask(input logic [2:0] d);
    logic [7:0] t;
    t = (8'h01 << d) - 8'h01;
    return t[6:0];
  endfunction : pre_mask

  // >= so a shrinking limit never strands the counter
  function automatic logic cnt_hit(input logic [6:0] c, input logic [6:0] lim);
    return c >= (lim - 7'h01);
  endfunction : cnt_hit

  function automatic logic [6:0] leg_lim(input logic t2, input logic dbl);
    if (t2) begin
      return T2_DIV;
    end
    return dbl ? T1_DIV_DBL : T1_DIV;
  endfunction : leg_lim

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    addr_ok = hsel & hready & htrans[1];
    // data phase of a write
    if (st_r.wr_pend_r) begin
      case (st_r.wr_addr_r)
        // R05 reserved bits
        ADDR_CTL: st_nxt.ctl_r = hwdata[7:0] & ~CTL_RSVD_MASK;
        ADDR_FD: st_nxt.fd_r = hwdata[7:0];
        ADDR_LEG: st_nxt.leg_r = hwdata[7:0];
        default: ;
      endcase
    end
    st_nxt.wr_pend_r = addr_ok & hwrite & (hsize == SIZE_WORD);
    st_nxt.wr_addr_r = haddr[7:0];
    // zero wait states, so no stall logic
    st_nxt.hreadyout_r = 1'b1;
    // read from updated copy so a write just landed is seen
    if (addr_ok & !hwrite) begin
      case (haddr[7:0])
        ADDR_CTL: st_nxt.hrdata_r = {24'h00_0000, st_nxt.ctl_r};
        ADDR_FD: st_nxt.hrdata_r = {24'h00_0000, st_nxt.fd_r};
        ADDR_LEG: st_nxt.hrdata_r = {24'h00_0000, st_nxt.leg_r};
        ADDR_STAT: begin
          st_nxt.hrdata_r = 32'h0000_0000;
          st_nxt.hrdata_r[STAT_ACT_BIT] = st_r.gen_act_r;
          st_nxt.hrdata_r[STAT_ACC_LSB +: 9] = st_r.acc_r;
        end
        default: st_nxt.hrdata_r = 32'h0000_0000;
      endcase
    end

    en = st_r.ctl_r[CTL_EN_BIT];
    var_mode = st_r.leg_r[0];
    // R01 dedicated source
    // R14 modes 1 and 3 only
    gen = en & var_mode;

    // R07 counts hclk, the core clock
    // R04 power-of-two prescale
    pre_mask_v = pre_mask(st_r.ctl_r[2:0]);
    pre_hit = st_r.pre_r >= pre_mask_v;
    // R10 nine-bit modulus covers every divide value
    modulus = {1'b0, st_r.fd_r} + FD_OFFSET;
    // acc stays below 320, so nine bits hold the sum
    sum = st_r.acc_r + GEN_STEP;
    gen_tick = 1'b0;
    if (!en) begin
      st_nxt.pre_r = 7'h00;
      st_nxt.acc_r = 9'h000;
    end else begin
      st_nxt.pre_r = pre_hit ? 7'h00 : st_r.pre_r + 7'h01;
      // R06 add two per prescaled tick, wrap at fd+64
      // R11 same arithmetic gives 230400 for 80h/2dh
      if (pre_hit) begin
        if (sum >= modulus) begin
          gen_tick = 1'b1;
          st_nxt.acc_r = sum - modulus;
        end else begin
          st_nxt.acc_r = sum;
        end
      end
    end

    // R12 legacy overflow sources per direction
    // R13 doubling in legacy path
    tx_ovf = st_r.leg_r[LEG_TX_TIMER_SELECT_BIT] ? t2_ovf : t1_ovf;
    rx_ovf = st_r.leg_r[LEG_RCLK_BIT] ? t2_ovf : t1_ovf;
    tx_lim = leg_lim(st_r.leg_r[LEG_TX_TIMER_SELECT_BIT], st_r.leg_r[LEG_DBL_BIT]);
    rx_lim = leg_lim(st_r.leg_r[LEG_RCLK_BIT], st_r.leg_r[LEG_DBL_BIT]);
    leg_tx = 1'b0;
    leg_rx = 1'b0;
    // R02 enabled: selects and doubling have no path
    if (gen | !var_mode) begin
      st_nxt.txd_r = 7'h00;
      st_nxt.rxd_r = 7'h00;
    end else begin
      // R03 legacy division when disabled
      if (tx_ovf) begin
        leg_tx = cnt_hit(st_r.txd_r, tx_lim);
        st_nxt.txd_r = leg_tx ? 7'h00 : st_r.txd_r + 7'h01;
      end
      if (rx_ovf) begin
        leg_rx = cnt_hit(st_r.rxd_r, rx_lim);
        st_nxt.rxd_r = leg_rx ? 7'h00 : st_r.rxd_r + 7'h01;
      end
    end

    // fixed modes 0 and 2, untouched by the generator
    if (st_r.leg_r[1]) begin
      // R13 mode-2 doubling
      fix_lim = st_r.leg_r[LEG_DBL_BIT] ? MODE2_DIV_DBL : MODE2_DIV;
    end else begin
      fix_lim = MODE0_DIV;
    end
    fix_tick = 1'b0;
    if (var_mode) begin
      st_nxt.fix_r = 7'h00;
    end else begin
      fix_tick = cnt_hit(st_r.fix_r, fix_lim);
      st_nxt.fix_r = fix_tick ? 7'h00 : st_r.fix_r + 7'h01;
    end

    // R14 one generator pulse feeds both directions
    if (gen) begin
      st_nxt.tx_en_r = gen_tick;
      st_nxt.rx_en_r = gen_tick;
    end else if (var_mode) begin
      st_nxt.tx_en_r = leg_tx;
      st_nxt.rx_en_r = leg_rx;
    end else begin
      st_nxt.tx_en_r = fix_tick;
      st_nxt.rx_en_r = fix_tick;
    end
    st_nxt.gen_act_r = gen;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
      st_r.ctl_r <= CTL_RESET;
      st_r.fd_r <= FD_RESET;
      st_r.leg_r <= LEG_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata = st_r.hrdata_r;
  assign hreadyout = st_r.hreadyout_r;
  assign hresp = 1'b0;
  assign tx_bit_en = st_r.tx_en_r;
  assign rx_bit_en = st_r.rx_en_r;
  assign gen_active = st_r.gen_act_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_gen_select: assert property (gen |=> st_r.gen_act_r) // R01
    else $error("generator not selected when enabled");
  a_legacy_ignored: assert property (gen && t1_ovf && t2_ovf |=> st_r.txd_r == 7'h00 && st_r.rxd_r == 7'h00) // R02
    else $error("legacy counters ran while generator enabled");
  a_disabled_idle: assert property (!en |=> st_r.acc_r == 9'h000 && st_r.pre_r == 7'h00) // R03
    else $error("generator ran while disabled");
  a_prescale_wrap: assert property (en && pre_hit |=> st_r.pre_r == 7'h00) // R04
    else $error("prescaler failed to wrap");
  a_reserved_zero: assert property (st_r.wr_pend_r && st_r.wr_addr_r == ADDR_CTL |=> st_r.ctl_r[6:3] == 4'h0) // R05
    else $error("reserved control bits stored");
  a_frac_tick: assert property (gen && pre_hit && sum >= modulus |=> st_r.tx_en_r && st_r.rx_en_r) // R06
    else $error("missing generator tick");
  a_frac_quiet: assert property (gen && !(pre_hit && sum >= modulus) |=> !st_r.tx_en_r) // R06
    else $error("spurious generator tick");
  a_tx_rx_same: assert property (st_r.gen_act_r && $past(gen) |-> st_r.tx_en_r == st_r.rx_en_r) // R14
    else $error("tx and rx ticks differ under generator");
  a_fixed_cause: assert property (!var_mode && st_nxt.tx_en_r |-> st_r.fix_r >= fix_lim - 7'h01) // R14
    else $error("fixed mode tick before count");
  a_leg_double: assert property (!gen && var_mode && st_r.leg_r[LEG_DBL_BIT] && !st_r.leg_r[LEG_TX_TIMER_SELECT_BIT] // R13
      |-> tx_lim == T1_DIV_DBL)
    else $error("doubling not applied to timer one path");
  a_bus_answer: assert property (addr_ok |=> hreadyout && !hresp)
    else $error("slave not ready with okay");

  // R04 prescale count step
  a_prescale_step: assert property (en && !pre_hit |=> st_r.pre_r == $past(st_r.pre_r) + 7'h01) // R04
    else $error("prescaler did not advance by one");
  // R12 tx overflow source
  a_tx_source: assert property (!gen && var_mode && st_r.leg_r[LEG_TX_TIMER_SELECT_BIT] && !t2_ovf |=> !st_r.tx_en_r) // R12
    else $error("tx tick without selected overflow");
  // R12 rx overflow source
  a_rx_source: assert property (!gen && var_mode && !rx_ovf |=> !st_r.rx_en_r) // R12
    else $error("rx tick without selected overflow");
  // R03 generator left unused
  a_gen_unused: assert property (!en |=> !st_r.gen_act_r) // R03
    else $error("generator marked active while disabled");
  // R01 status shows source
  a_stat_active: assert property (addr_ok && !hwrite && haddr[7:0] == ADDR_STAT // R01
      |=> st_r.hrdata_r[STAT_ACT_BIT] == $past(st_r.gen_act_r))
    else $error("status read lost active flag");
  // R06 divide value stored
  a_fd_store: assert property (st_r.wr_pend_r && st_r.wr_addr_r == ADDR_FD // R06
      |=> st_r.fd_r == $past(hwdata[7:0]))
    else $error("fractional divide value not stored");
  // R14 fixed modes quiet
  a_fixed_quiet: assert property (!var_mode && !cnt_hit(st_r.fix_r, fix_lim) // R14
      |=> !st_r.tx_en_r && !st_r.rx_en_r)
    else $error("fixed mode tick before count");

  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------
  c_gen_tick: cover property (gen ##1 st_r.tx_en_r);
  c_legacy_t2: cover property (!en && var_mode && st_r.leg_r[LEG_TX_TIMER_SELECT_BIT] ##1 st_r.tx_en_r);
  c_mode2: cover property (st_r.leg_r[1:0] == 2'b10 ##1 st_r.tx_en_r);
  c_ctl_write: cover property (st_r.wr_pend_r && st_r.wr_addr_r == ADDR_CTL);
  c_stat_read: cover property (addr_ok && !hwrite && haddr[7:0] == ADDR_STAT);

endmodule : fbrg_top

// ### tb/fbrg_serial_model.sv
// serial port side model: timer overflow source and bit pulse counters
`timescale 1ns/10ps
module fbrg_serial_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tx_bit_en,
  input wire logic rx_bit_en,
  output logic t1_ovf,
  output logic t2_ovf,
  output logic [15:0] tx_cnt,
  output logic [15:0] rx_cnt
);
  // ------------------------------------------------
  // overflows and counts
  // ------------------------------------------------
  logic [3:0] ph_r;
  // overflows every 4 and 6 cycles, pulses counted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_r <= 4'h0;
      t1_ovf <= 1'b0;
      t2_ovf <= 1'b0;
      tx_cnt <= 16'h0000;
      rx_cnt <= 16'h0000;
    end else begin
      ph_r <= (ph_r == 4'hb) ? 4'h0 : ph_r + 4'h1;
      t1_ovf <= (ph_r[1:0] == 2'h3);
      t2_ovf <= (ph_r == 4'h5) || (ph_r == 4'hb);
      tx_cnt <= tx_cnt + 16'(tx_bit_en);
      rx_cnt <= rx_cnt + 16'(rx_bit_en);
    end
  end
endmodule : fbrg_serial_model

// ### tb/fbrg_top_tb.sv
// self-checking testbench of the fractional baud rate generator
`timescale 1ns/10ps
module fbrg_top_tb;
  import fbrg_pkg::*;
  // ------------------------------------------------
  // bench
  // ------------------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout, hresp, t1_ovf, t2_ovf, tx_bit_en, rx_bit_en, gen_active;
  logic [15:0] tx_cnt, rx_cnt;
  int error_cnt = 0;
  int checks_done = 0;
  always #4 hclk = ~hclk;
  fbrg_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .t1_ovf(t1_ovf), .t2_ovf(t2_ovf),
    .tx_bit_en(tx_bit_en), .rx_bit_en(rx_bit_en), .gen_active(gen_active));
  fbrg_serial_model i_far (.hclk(hclk), .hresetn(hresetn), .tx_bit_en(tx_bit_en),
    .rx_bit_en(rx_bit_en), .t1_ovf(t1_ovf), .t2_ovf(t2_ovf), .tx_cnt(tx_cnt), .rx_cnt(rx_cnt));
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wait_tx(input logic rdy, output int m);
    m = 0;
    do begin
      @(posedge hclk);
      m++;
    end while ((rdy ? hreadyout : tx_bit_en) !== 1'b1 && m < 5000);
    if (m >= 5000) begin
      error_cnt++;
      $display("ERROR wait expected 1 seen 0");
      end_of_test();
    end
  endtask : wait_tx
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int m;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    hsize <= SIZE_WORD;
    wait_tx(1'b1, m);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_tx(1'b1, m);
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    chk("register", e, r);
  endtask : rd
  // two pulses skipped so old settings have drained
  task automatic rate(input logic [7:0] leg, input logic [7:0] ctl, input logic [7:0] fd, input int n,
    input int e);
    int c;
    int m;
    wr(ADDR_FD, {24'h00_0000, fd});
    wr(ADDR_LEG, {24'h00_0000, leg});
    wr(ADDR_CTL, {24'h00_0000, ctl});
    c = 0;
    for (int k = 0; k < n + 2; k++) begin
      wait_tx(1'b0, m);
      if (k >= 2) c += m;
    end
    chk("period", 32'(e), 32'(c));
  endtask : rate
  task automatic t_regs;
    rd(ADDR_CTL, 32'h0000_0000);
    wr(ADDR_CTL, 32'h0000_00ff);
    rd(ADDR_CTL, 32'h0000_0087);
    wr(ADDR_FD, 32'h0000_002d);
    rd(ADDR_FD, 32'h0000_002d);
    rd(8'h10, 32'h0000_0000);
    $display("test regs done");
  endtask : t_regs
  task automatic t_gen;
    logic [15:0] d0;
    logic [31:0] r;
    rate(8'h01, 8'h80, 8'h00, 1, 32);
    chk("gen_active", 32'h0000_0001, 32'(gen_active));
    d0 = tx_cnt - rx_cnt;
    chk("pairing", 32'h0000_0000, 32'(d0));
    for (int d = 0; d < 8; d++) rate(8'h01, 8'h80 | 8'(d), 8'h00, 1, 32 << d);
    rate(8'h01, 8'h80, 8'h2d, 2, 109);
    rate(8'h03, 8'h80, 8'h12, 1, 41);
    chk("pairing", 32'h0000_0000, 32'(16'(tx_cnt - rx_cnt)));
    bus(1'b0, ADDR_STAT, 32'h0000_0000, r);
    chk("status_active", 32'h0000_0001, r & 32'hfffe_00ff);
    $display("test gen done");
  endtask : t_gen
  // software settings for a wanted period of 200 clocks
  task automatic t_formula;
    int p;
    int dv;
    int fd;
    p = 200;
    dv = 0;
    while ((32 << (dv + 1)) <= p && dv < 7) dv++;
    fd = (2 * p + (1 << dv) / 2) / (1 << dv) - 64;
    rate(8'h01, 8'h80 | 8'(dv), 8'(fd), 1, p);
    $display("test formula done");
  endtask : t_formula
  task automatic t_ignore;
    rate(8'hb1, 8'h80, 8'h00, 1, 32);
    $display("test ignore done");
  endtask : t_ignore
  task automatic t_legacy;
    logic [15:0] t0;
    logic [15:0] r0;
    rate(8'h01, 8'h00, 8'h00, 1, 128);
    chk("gen_active", 32'h0000_0000, 32'(gen_active));
    rd(ADDR_STAT, 32'h0000_0000);
    rate(8'h81, 8'h00, 8'h00, 1, 64);
    rate(8'h11, 8'h00, 8'h00, 1, 96);
    t0 = tx_cnt;
    r0 = rx_cnt;
    // 384 clocks hold four tx and three rx periods exactly
    repeat (384) @(posedge hclk);
    chk("tx_pulses", 32'h0000_0004, 32'(16'(tx_cnt - t0)));
    chk("rx_pulses", 32'h0000_0003, 32'(16'(rx_cnt - r0)));
    $display("test legacy done");
  endtask : t_legacy
  task automatic t_fixed;
    rate(8'h00, 8'h80, 8'h00, 1, 12);
    rate(8'h02, 8'h80, 8'h00, 1, 64);
    rate(8'h82, 8'h80, 8'h00, 1, 32);
    $display("test fixed done");
  endtask : t_fixed
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_gen();
    t_formula();
    t_ignore();
    t_legacy();
    t_fixed();
    end_of_test();
  end
endmodule : fbrg_top_tb
